// ===== core/link_irq_pkg.sv
// Package for the link event interrupt routing block.
// Assumes an AXI4-Lite register slave with 32-bit data and byte addresses.
package link_irq_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] BRIDGE_CONFIG_RESERVED_OFS = 12'h200;  // Reserved RW word
    localparam logic [11:0] LINK_EVENT_IRQ_CONTROL_OFS = 12'h210;  // Action fields
    localparam logic [11:0] EXT_CAP_HEADER_OFS         = 12'h100;  // All-zero header
    localparam logic [11:0] IRQ_ENABLES_OFS            = 12'h214;  // MSI enable, INTx disable

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int          ACTION_WIDTH    = 3;                   // Bits per action field
    localparam int          EVENT_COUNT     = 6;                   // Up/down for three ports
    localparam logic [31:0] CONTROL_RESET   = 32'h0000_0000;       // All fields disabled
    localparam logic [31:0] RESERVED_RESET  = 32'h0000_0000;
    localparam logic [31:0] EXT_CAP_VALUE   = 32'h0000_0000;       // Id, version, next all zero
    localparam int          MSI_ENABLE_BIT  = 0;                   // In enables word
    localparam int          INTX_DISABLE_BIT = 1;                  // In enables word

    // ------------------------------------------------------------
    // Action encodings
    // ------------------------------------------------------------
    localparam logic [2:0] ACT_DISABLED = 3'h0;
    localparam logic [2:0] ACT_MSI      = 3'h1;
    localparam logic [2:0] ACT_INTA     = 3'h2;
    localparam logic [2:0] ACT_INTD     = 3'h5;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== core/event_action_decode.sv
// One link event: decodes its action field and watches its status bit.
// Assumes the status bit is synchronous to ref_clk.
`timescale 1ns/100ps
module event_action_decode (
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic [2:0] action,       // Action code for this event
    input  wire logic       statusBit,    // Event status level
    output logic            msiReq,       // One-cycle MSI request
    output logic [3:0]      intxAssert,   // One-cycle assert per INTA..INTD
    output logic [3:0]      intxNegate    // One-cycle negate per INTA..INTD
);
    // ------------------------------------------------------------
    // Edge detection of the status bit
    // ------------------------------------------------------------
    logic statusLast;        // Status seen last cycle
    logic next_statusLast;

    always_comb begin
        next_statusLast = statusBit;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            statusLast <= 1'b0;
        end else begin
            statusLast <= next_statusLast;
        end
    end

    // ------------------------------------------------------------
    // Action decode, combinational
    // ------------------------------------------------------------
    always_comb begin
        logic       rise;
        logic       fall;
        logic [2:0] lane;
        rise       = statusBit & ~statusLast;
        fall       = ~statusBit & statusLast;
        lane       = 3'h0;
        msiReq     = 1'b0;
        intxAssert = 4'h0;
        intxNegate = 4'h0;
        // Codes above INTD fall through as disabled, so no stray traffic
        if (action == link_irq_pkg::ACT_MSI) begin
            msiReq = rise;
        end else if (action >= link_irq_pkg::ACT_INTA &&
                     action <= link_irq_pkg::ACT_INTD) begin
            lane = action - link_irq_pkg::ACT_INTA;
            intxAssert[lane[1:0]] = rise;
            intxNegate[lane[1:0]] = fall;
        end
    end
endmodule

// ===== core/link_event_interrupt_routing.sv
// Link event interrupt routing: action registers, AXI4-Lite slave, message requests.
// Assumes event status levels and all AXI signals are synchronous to ref_clk.
//
// How it works
// - Code 0 masks, 1 MSI, 2-5 INTA-INTD.
// - MSI only while MSI enable set.
// - INTx messages suppressed while interrupt-disable set.
// - Act on set; INTx also negates on clear.
// - Fields at 2:0, 5:3, 8:6, reset zero.
// - Extended capability header reads all zeros.
// - Further fields at 11:9, 14:12, 17:15.
`timescale 1ns/100ps
module link_event_interrupt_routing (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // Event status, one bit per event: A up, A down, B up, B down, C up, C down
    input  wire logic [5:0]  eventStatus,
    // AXI4-Lite slave
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Message requests toward the upstream link
    output logic             msiSend,       // One-cycle MSI request
    output logic [3:0]       intxAssertMsg, // One-cycle assert, bit 0 = INTA
    output logic [3:0]       intxNegateMsg  // One-cycle negate, bit 0 = INTA
);
    localparam int N = link_irq_pkg::EVENT_COUNT;
    localparam int W = link_irq_pkg::ACTION_WIDTH;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [31:0] controlReg;        // Action fields
    logic [31:0] reservedReg;       // Reserved scratch word
    logic [1:0]  enablesReg;        // MSI enable and INTx disable
    logic [11:0] awAddr;            // Latched write address
    logic        awHeld;
    logic [31:0] wData;             // Latched write data
    logic [3:0]  wStrb;
    logic        wHeld;
    logic [31:0] next_controlReg;
    logic [31:0] next_reservedReg;
    logic [1:0]  next_enablesReg;
    logic [11:0] next_awAddr;
    logic        next_awHeld;
    logic [31:0] next_wData;
    logic [3:0]  next_wStrb;
    logic        next_wHeld;
    logic        next_bvalid;
    logic [1:0]  next_bresp;
    logic        next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;

    // Byte-lane merge of write data into a word
    function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // Bus slave next state
    // ------------------------------------------------------------
    // Address and data are accepted independently; response once both held
    always_comb begin
        logic doWrite;
        doWrite          = 1'b0;
        next_controlReg  = controlReg;
        next_reservedReg = reservedReg;
        next_enablesReg  = enablesReg;
        next_awAddr      = awAddr;
        next_awHeld      = awHeld;
        next_wData       = wData;
        next_wStrb       = wStrb;
        next_wHeld       = wHeld;
        next_bvalid      = s_axi_bvalid;
        next_bresp       = s_axi_bresp;
        next_rvalid      = s_axi_rvalid;
        next_rdata       = s_axi_rdata;
        next_rresp       = s_axi_rresp;
        // Capture channels
        if (s_axi_awvalid && s_axi_awready) begin
            next_awAddr = s_axi_awaddr;
            next_awHeld = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_wData = s_axi_wdata;
            next_wStrb = s_axi_wstrb;
            next_wHeld = 1'b1;
        end
        // Commit a write once both halves are in and no response pending
        if (awHeld && wHeld && !s_axi_bvalid) begin
            doWrite     = 1'b1;
            next_awHeld = 1'b0;
            next_wHeld  = 1'b0;
            next_bvalid = 1'b1;
            next_bresp  = link_irq_pkg::RESP_OKAY;
        end
        if (doWrite) begin
            case ({awAddr[11:2], 2'h0})
                link_irq_pkg::LINK_EVENT_IRQ_CONTROL_OFS: begin
                    // Upper bits above the fields stay zero
                    next_controlReg = mergeBytes(controlReg, wData, wStrb)
                                      & 32'h0003_ffff;
                end
                link_irq_pkg::BRIDGE_CONFIG_RESERVED_OFS: begin
                    next_reservedReg = mergeBytes(reservedReg, wData, wStrb);
                end
                link_irq_pkg::IRQ_ENABLES_OFS: begin
                    if (wStrb[0]) begin
                        next_enablesReg = wData[1:0];
                    end
                end
                link_irq_pkg::EXT_CAP_HEADER_OFS: begin
                    // Read-only, write dropped
                end
                default: begin
                    next_bresp = link_irq_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        // Read: answer one cycle after the address is taken
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = link_irq_pkg::RESP_OKAY;
            case ({s_axi_araddr[11:2], 2'h0})
                link_irq_pkg::LINK_EVENT_IRQ_CONTROL_OFS: next_rdata = controlReg;
                link_irq_pkg::BRIDGE_CONFIG_RESERVED_OFS: next_rdata = reservedReg;
                link_irq_pkg::IRQ_ENABLES_OFS: next_rdata = {30'h0, enablesReg};
                link_irq_pkg::EXT_CAP_HEADER_OFS: begin
                    next_rdata = link_irq_pkg::EXT_CAP_VALUE;
                end
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = link_irq_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    // Ready terms registered so every output comes from a flip-flop
    logic next_awready;
    logic next_wready;
    logic next_arready;

    always_comb begin
        next_awready = !next_awHeld;
        next_wready  = !next_wHeld;
        // One read at a time; ready drops while the answer is pending
        next_arready = !next_rvalid;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            controlReg    <= link_irq_pkg::CONTROL_RESET;
            reservedReg   <= link_irq_pkg::RESERVED_RESET;
            enablesReg    <= 2'h0;
            awAddr        <= 12'h000;
            awHeld        <= 1'b0;
            wData         <= 32'h0000_0000;
            wStrb         <= 4'h0;
            wHeld         <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= link_irq_pkg::RESP_OKAY;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= link_irq_pkg::RESP_OKAY;
        end else begin
            controlReg    <= next_controlReg;
            reservedReg   <= next_reservedReg;
            enablesReg    <= next_enablesReg;
            awAddr        <= next_awAddr;
            awHeld        <= next_awHeld;
            wData         <= next_wData;
            wStrb         <= next_wStrb;
            wHeld         <= next_wHeld;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_arready <= next_arready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end
    end

    // ------------------------------------------------------------
    // Per-event decoders
    // ------------------------------------------------------------
    logic [N-1:0] evMsi;            // MSI request per event
    logic [3:0]   evAssert [N];     // Assert lanes per event
    logic [3:0]   evNegate [N];     // Negate lanes per event

    for (genvar e = 0; e < N; e++) begin : g_event
        event_action_decode u_decode (
            .ref_clk    (ref_clk),
            .sys_rst    (sys_rst),
            .action     (controlReg[e*W +: W]),
            .statusBit  (eventStatus[e]),
            .msiReq     (evMsi[e]),
            .intxAssert (evAssert[e]),
            .intxNegate (evNegate[e])
        );
    end

    // ------------------------------------------------------------
    // Gating and merge of message requests
    // ------------------------------------------------------------
    logic       next_msiSend;
    logic [3:0] next_intxAssert;
    logic [3:0] next_intxNegate;

    // Simultaneous events on one lane merge into a single message
    always_comb begin
        logic [3:0] a;
        logic [3:0] n;
        a = 4'h0;
        n = 4'h0;
        for (int e = 0; e < N; e++) begin
            a = a | evAssert[e];
            n = n | evNegate[e];
        end
        next_msiSend    = (|evMsi) & enablesReg[link_irq_pkg::MSI_ENABLE_BIT];
        next_intxAssert = enablesReg[link_irq_pkg::INTX_DISABLE_BIT] ? 4'h0 : a;
        next_intxNegate = enablesReg[link_irq_pkg::INTX_DISABLE_BIT] ? 4'h0 : n;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            msiSend       <= 1'b0;
            intxAssertMsg <= 4'h0;
            intxNegateMsg <= 4'h0;
        end else begin
            msiSend       <= next_msiSend;
            intxAssertMsg <= next_intxAssert;
            intxNegateMsg <= next_intxNegate;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_msi_gated: assert property (@(posedge ref_clk) disable iff (sys_rst)
        msiSend |-> $past(enablesReg[link_irq_pkg::MSI_ENABLE_BIT]))
        else $error("MSI sent while disabled");
    a_intx_gated: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (intxAssertMsg != 4'h0 || intxNegateMsg != 4'h0)
        |-> !$past(enablesReg[link_irq_pkg::INTX_DISABLE_BIT]))
        else $error("INTx sent while disabled");
    a_msi_rise: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (eventStatus[0] && !$past(eventStatus[0]) && controlReg[2:0] == 3'h1
         && enablesReg == 2'h1) |=> msiSend)
        else $error("MSI missing on link up");
    a_inta_fall: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!eventStatus[1] && $past(eventStatus[1]) && controlReg[5:3] == 3'h2
         && $stable(controlReg) && !enablesReg[1]) |=> intxNegateMsg[0])
        else $error("INTA negate missing");
    a_reserved_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (controlReg == 32'h0003_ffff && $stable(controlReg)) |=> !msiSend
        && intxAssertMsg == 4'h0)
        else $error("Reserved code sent a message");
    a_ext_cap_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (s_axi_arvalid && s_axi_arready
         && s_axi_araddr == link_irq_pkg::EXT_CAP_HEADER_OFS)
        |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000)
        else $error("Capability header not zero");
    a_ctrl_upper_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
        controlReg[31:18] == 14'h0)
        else $error("Control bits above fields set");
    a_disabled_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (controlReg == 32'h0 && $past(controlReg) == 32'h0) |=> !msiSend
        && intxAssertMsg == 4'h0 && intxNegateMsg == 4'h0)
        else $error("Disabled event sent a message");
endmodule

// ===== verification/irq_host_model.sv
// Host side model: receives the interrupt messages that the block sends upstream.
// Assumes one-cycle request pulses synchronous to ref_clk, bit 0 of each lane vector INTA.
`timescale 1ns/100ps
module irq_host_model (
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic       msiSend,
    input  wire logic [3:0] intxAssertMsg,
    input  wire logic [3:0] intxNegateMsg,
    output logic      [7:0] msiCount,   // MSI messages taken
    output logic      [3:0] intxLevel,  // Virtual INTA..INTD wire state
    output logic            badMsg      // Sticky: negate with no assert standing
);
    // ----------------------------------------
    // Message bookkeeping
    // ----------------------------------------
    logic [7:0] next_msiCount;
    logic [3:0] next_intxLevel;
    logic       next_badMsg;

    // A host only sees messages; a stray negate is a protocol slip worth flagging
    always_comb begin
        next_msiCount  = msiCount + {7'h0, msiSend};
        next_intxLevel = (intxLevel | intxAssertMsg) & ~intxNegateMsg;
        next_badMsg    = badMsg | (|(intxNegateMsg & ~intxLevel));
    end

    // Plain registers, cleared by the shared reset
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            msiCount  <= 8'h00;
            intxLevel <= 4'h0;
            badMsg    <= 1'b0;
        end else begin
            msiCount  <= next_msiCount;
            intxLevel <= next_intxLevel;
            badMsg    <= next_badMsg;
        end
    end
endmodule

// ===== verification/tb_link_event_interrupt_routing.sv
// Self-checking bench for the link event interrupt routing block.
// Assumes the package and the host model are compiled first; one 125 MHz clock.
`timescale 1ns/100ps
module tb_link_event_interrupt_routing;
    // ----------------------------------------
    // Signals and offsets
    // ----------------------------------------
    localparam logic [11:0] CTRL = link_irq_pkg::LINK_EVENT_IRQ_CONTROL_OFS;
    localparam logic [11:0] ENA  = link_irq_pkg::IRQ_ENABLES_OFS;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [5:0]  eventStatus = 6'h00;  // Link event levels
    logic [11:0] awaddr = 12'h000;
    logic        awvalid = 1'b0;
    logic        awready;
    logic [31:0] wdata = 32'h0;
    logic        wvalid = 1'b0;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready = 1'b0;
    logic [11:0] araddr = 12'h000;
    logic        arvalid = 1'b0;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready = 1'b0;
    logic        msiSend;
    logic [3:0]  intxAssertMsg;
    logic [3:0]  intxNegateMsg;
    logic [7:0]  msiCount;
    logic [3:0]  intxLevel;
    logic        badMsg;
    logic [1:0]  lastResp;  // Response of the latest bus access
    int          error_cnt = 0;
    int          cmp_count = 0;

    always #4 ref_clk = ~ref_clk;

    link_event_interrupt_routing DUT (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .eventStatus(eventStatus), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .msiSend(msiSend), .intxAssertMsg(intxAssertMsg), .intxNegateMsg(intxNegateMsg));

    irq_host_model host (.ref_clk(ref_clk), .sys_rst(sys_rst), .msiSend(msiSend),
        .intxAssertMsg(intxAssertMsg), .intxNegateMsg(intxNegateMsg),
        .msiCount(msiCount), .intxLevel(intxLevel), .badMsg(badMsg));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask

    // Offers address and data together; each released once taken
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge ref_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        lastResp = bresp;
        bready <= 1'b0;
        if (n == 40) chk("write response", 32'h1, 32'h0);
    endtask

    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d);
        int n;
        @(posedge ref_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge ref_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata;
        lastResp = rresp;
        rready <= 1'b0;
        if (n == 40) chk("read response", 32'h1, 32'h0);
    endtask

    // Moves one status level, then leaves room for the one-cycle answer to land
    task automatic set_event(input int e, input logic lvl);
        @(posedge ref_clk);
        eventStatus[e] <= lvl;
        repeat (4) @(posedge ref_clk);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        logic [31:0] d;
        axi_rd(CTRL, d);
        chk("control reset", 32'h0, d);
        axi_rd(link_irq_pkg::BRIDGE_CONFIG_RESERVED_OFS, d);
        chk("reserved reset", 32'h0, d);
        axi_wr(CTRL, 32'hffff_ffff);
        chk("control wr resp", {30'h0, link_irq_pkg::RESP_OKAY}, {30'h0, lastResp});
        axi_rd(CTRL, d);
        chk("control width", 32'h0003_ffff, d);
        // Every field now holds reserved code 7: a set on event 2 must stay silent
        axi_wr(ENA, 32'h1);
        set_event(2, 1'b1);
        chk("reserved msi", 32'h0, {24'h0, msiCount});
        chk("reserved intx", 32'h0, {28'h0, intxLevel});
        set_event(2, 1'b0);
        axi_wr(link_irq_pkg::EXT_CAP_HEADER_OFS, 32'hffff_ffff);
        chk("ext cap wr resp", {30'h0, link_irq_pkg::RESP_OKAY}, {30'h0, lastResp});
        axi_rd(link_irq_pkg::EXT_CAP_HEADER_OFS, d);
        chk("ext cap header", 32'h0, d);
        axi_wr(link_irq_pkg::BRIDGE_CONFIG_RESERVED_OFS, 32'ha5a5_5a5a);
        axi_rd(link_irq_pkg::BRIDGE_CONFIG_RESERVED_OFS, d);
        chk("reserved word", 32'ha5a5_5a5a, d);
        axi_rd(12'h300, d);
        chk("unmapped resp", {30'h0, link_irq_pkg::RESP_SLVERR}, {30'h0, lastResp});
        chk("unmapped data", 32'h0, d);
        axi_wr(12'h300, 32'hffff_ffff);
        chk("unmapped wr resp", {30'h0, link_irq_pkg::RESP_SLVERR}, {30'h0, lastResp});
        $display("test regs done");
    endtask

    // Every code on every event; fields change only while status is low
    // Software keeps to codes 0-5 elsewhere, except t_regs, which leaves code 7 in every field;
    // here 6 and 7 probe that reserved codes stay silent on every event
    task automatic t_codes();
        logic [31:0] d;
        logic [7:0]  m0;
        logic [3:0]  lane;
        axi_wr(ENA, 32'h1);
        for (int e = 0; e < 6; e++) begin
            for (int c = 0; c < 8; c++) begin
                axi_wr(CTRL, 32'(c) << (3 * e));
                axi_rd(CTRL, d);
                chk("action field", 32'(c) << (3 * e), d);
                m0 = msiCount;
                lane = (c >= 2 && c <= 5) ? 4'h1 << (c - 2) : 4'h0;
                set_event(e, 1'b1);
                chk("msi on set", {24'h0, m0 + 8'(c == 1)}, {24'h0, msiCount});
                chk("intx on set", {28'h0, lane}, {28'h0, intxLevel});
                set_event(e, 1'b0);
                chk("msi on clear", {24'h0, m0 + 8'(c == 1)}, {24'h0, msiCount});
                chk("intx on clear", 32'h0, {28'h0, intxLevel});
            end
        end
        chk("stray negate", 32'h0, {31'h0, badMsg});
        $display("test codes done");
    endtask

    task automatic t_gate();
        logic [7:0] m0;
        axi_wr(ENA, 32'h0);
        axi_wr(CTRL, 32'h0000_0011);
        m0 = msiCount;
        set_event(0, 1'b1);
        chk("msi while off", {24'h0, m0}, {24'h0, msiCount});
        set_event(0, 1'b0);
        axi_wr(ENA, 32'h3);
        set_event(1, 1'b1);
        chk("assert while off", 32'h0, {28'h0, intxLevel});
        set_event(1, 1'b0);
        axi_wr(ENA, 32'h1);
        set_event(1, 1'b1);
        chk("assert while on", 32'h1, {28'h0, intxLevel});
        axi_wr(ENA, 32'h3);
        set_event(1, 1'b0);
        chk("negate while off", 32'h1, {28'h0, intxLevel});
        chk("stray negate", 32'h0, {31'h0, badMsg});
        $display("test gate done");
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_codes();
        t_gate();
        wrap_up();
    end

    // Tests need about 1,000 cycles; far more means a hang
    initial begin
        #(8 * 20000);
        error_cnt++;
        wrap_up();
    end
endmodule
